// ==== crp_defs.vh ====
`ifndef CRP_DEFS_VH
`define CRP_DEFS_VH

// Address of the word that holds the restart address.
`define CRP_RESET_VECTOR      22'h3FFFC0
// Program counter width and increment per fetched word.
`define CRP_PC_W              22
`define CRP_PC_STEP           22'h000001
// Ratio field values of the external timing clock.
`define CRP_RATIO_FULL        3'h0
// Reset values of the clock output configuration (divide by four).
`define CRP_RATIO_RST         3'h1
`define CRP_HALF_RST          1'h1
`define CRP_DISABLE_RST       1'h0
// Width and terminal value of the oscillator cycle counter for the pin drive.
`define CRP_WD_CNT_W          10
`define CRP_WD_LAST           10'h1FF
`define CRP_WD_ZERO           10'h000
// Divider counter width, reset value and bit positions for /2 and /4.
`define CRP_DIV_W             2
`define CRP_DIV_ZERO          2'h0
`define CRP_DIV_ONE           2'h1
`define CRP_DIV2_BIT          0
`define CRP_DIV4_BIT          1
// Sequencer state codes.
`define CRP_ST_W              2
`define CRP_ST_VECTOR         2'h0
`define CRP_ST_HOLD           2'h1
`define CRP_ST_RUN            2'h2

`endif

// ==== crp_sync2.v ====
`timescale 1ns/100ps

module crp_sync2 #(
  parameter       WIDTH   = 1,
  parameter [0:0] RST_VAL = 1'h0
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // Two flip-flops in series; only the second one is visible outside.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_ff <= {WIDTH{RST_VAL}};
      sync_ff <= {WIDTH{RST_VAL}};
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // crp_sync2

// ==== crp_clock_reset_pins.v ====
// Overview of operation
// - The clock output runs at the system clock rate, half or a quarter of it, chosen by the ratio field and the half select bit.
// - After reset the clock output runs at a quarter of the system clock until a new selection is written.
// - Writing the disable bit as one stops the clock output from toggling.
// - The clock output pin stays actively driven during reset and is never released.
// - While the reset pin is low all instruction execution is stopped.
// - During reset the program counter is loaded with the address stored at location 0x3FFFC0.
// - When the reset pin returns high, fetching and execution start at the program counter.
// - A watchdog reset drives the reset pin low for exactly 512 oscillator clock cycles and then releases it.
// - The reset pin is only ever pulled low, the high level comes from a pullup, and outside drivers should be open drain too.
`timescale 1ns/100ps
`include "crp_defs.vh"

module crp_clock_reset_pins (
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire                    cfg_wr,
  input  wire [2:0]              cfg_ext_timing_clock_ratio,
  input  wire                    cfg_clock_out_half_select,
  input  wire                    cfg_clock_out_disable,
  output wire [2:0]              ext_timing_clock_ratio,
  output wire                    clock_out_half_select,
  output wire                    clock_out_disable,
  output wire                    clock_out_pin,
  output wire                    clock_out_pin_oe_n,
  input  wire                    oscillator_clock,
  input  wire                    wdog_reset_req,
  input  wire                    reset_pin_n_in,
  output wire                    reset_pin_n_out,
  output wire                    reset_pin_n_oe_n,
  output wire                    core_reset_n,
  output wire                    exec_en,
  output wire                    mem_req,
  output wire [`CRP_PC_W-1:0]    mem_addr,
  input  wire                    mem_ack,
  input  wire [`CRP_PC_W-1:0]    mem_rdata,
  output wire [`CRP_PC_W-1:0]    pc
);

  reg  [2:0]               ratio_ff;
  reg                      half_ff;
  reg                      disable_ff;
  reg  [`CRP_DIV_W-1:0]    div_cnt_ff;
  reg                      div_out_ff;
  reg                      nxt_div_out;
  reg                      osc_prev_ff;
  reg                      drive_ff;
  reg  [`CRP_WD_CNT_W-1:0] wd_cnt_ff;
  reg  [`CRP_ST_W-1:0]     state_ff;
  reg  [`CRP_ST_W-1:0]     nxt_state;
  reg  [`CRP_PC_W-1:0]     pc_ff;
  reg  [`CRP_PC_W-1:0]     nxt_pc;
  reg                      core_rst_n_ff;
  reg                      exec_en_ff;
  wire [1:0]               pin_sync;
  wire                     pin_high;
  wire                     osc_sync;
  wire                     osc_rise;
  wire                     div_by_one;
  wire                     div_by_two;
  wire                     in_reset;

  // Both pin inputs come from outside the clock domain.
  crp_sync2 #(
    .WIDTH   (2),
    .RST_VAL (1'h1)
  ) u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({oscillator_clock, reset_pin_n_in}),
    .sync_out (pin_sync)
  );

  assign pin_high = pin_sync[0];
  assign osc_sync = pin_sync[1];
  assign osc_rise = osc_sync & ~osc_prev_ff;

  // Internal reset follows the pin level, whoever pulls it low.
  assign in_reset = ~pin_high | drive_ff;

  // Clock output configuration, back to divide by four on any reset.
  always @(posedge clk)
  begin
    if (!rst_n || in_reset)
    begin
      ratio_ff   <= `CRP_RATIO_RST;
      half_ff    <= `CRP_HALF_RST;
      disable_ff <= `CRP_DISABLE_RST;
    end
    else if (cfg_wr)
    begin
      ratio_ff   <= cfg_ext_timing_clock_ratio;
      half_ff    <= cfg_clock_out_half_select;
      disable_ff <= cfg_clock_out_disable;
    end
  end

  assign ext_timing_clock_ratio = ratio_ff;
  assign clock_out_half_select  = half_ff;
  assign clock_out_disable      = disable_ff;

  // Any nonzero ratio halves the timing clock; half select halves it again.
  assign div_by_one = (ratio_ff == `CRP_RATIO_FULL) & ~half_ff;
  assign div_by_two = (ratio_ff == `CRP_RATIO_FULL) ^ ~half_ff;

  // Free running divider; only a power-on reset clears it.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_cnt_ff <= `CRP_DIV_ZERO;
      div_out_ff <= 1'h0;
    end
    else
    begin
      div_cnt_ff <= div_cnt_ff + `CRP_DIV_ONE;
      div_out_ff <= nxt_div_out;
    end
  end

  // Select the registered divided phase; a stopped output sits low.
  always @*
  begin
    if (disable_ff)
      nxt_div_out = 1'h0;
    else if (div_by_two)
      nxt_div_out = ~div_cnt_ff[`CRP_DIV2_BIT];
    else
      nxt_div_out = div_cnt_ff[`CRP_DIV4_BIT];
  end

  // Full rate passes the system clock itself through the output mux.
  assign clock_out_pin = div_by_one ? (clk & ~disable_ff) : div_out_ff;
  // The pin is driven at all times, reset included.
  assign clock_out_pin_oe_n = 1'h0;

  // Watchdog drive of the reset pin, timed in oscillator rising edges.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      osc_prev_ff <= 1'h1; // Same as the synchroniser, so no false rise.
      drive_ff    <= 1'h0;
      wd_cnt_ff   <= `CRP_WD_ZERO;
    end
    else
    begin
      osc_prev_ff <= osc_sync;
      if (!drive_ff)
      begin
        if (wdog_reset_req)
        begin
          drive_ff  <= 1'h1;
          wd_cnt_ff <= `CRP_WD_ZERO;
        end
      end
      else if (osc_rise)
      begin
        if (wd_cnt_ff == `CRP_WD_LAST)
        begin
          drive_ff  <= 1'h0;
          wd_cnt_ff <= `CRP_WD_ZERO;
        end
        else
          wd_cnt_ff <= wd_cnt_ff + {{(`CRP_WD_CNT_W-1){1'h0}}, 1'h1};
      end
    end
  end

  // Open drain: the output data is always low, only the enable moves.
  assign reset_pin_n_out  = 1'h0;
  assign reset_pin_n_oe_n = ~drive_ff;

  // Next state and program counter of the restart sequencer.
  always @*
  begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    case (state_ff)
      `CRP_ST_VECTOR:
      begin
        if (mem_ack)
        begin
          nxt_pc    = mem_rdata;
          nxt_state = `CRP_ST_HOLD;
        end
      end
      `CRP_ST_HOLD:
      begin
        if (!in_reset)
          nxt_state = `CRP_ST_RUN;
      end
      `CRP_ST_RUN:
      begin
        if (mem_ack)
          nxt_pc = pc_ff + `CRP_PC_STEP;
      end
      default:
      begin
        nxt_state = `CRP_ST_VECTOR;
      end
    endcase
    if (in_reset && state_ff == `CRP_ST_RUN)
      nxt_state = `CRP_ST_VECTOR;
  end

  // Sequencer registers and the registered core controls.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_ff      <= `CRP_ST_VECTOR;
      pc_ff         <= `CRP_RESET_VECTOR;
      core_rst_n_ff <= 1'h0;
      exec_en_ff    <= 1'h0;
    end
    else
    begin
      state_ff      <= nxt_state;
      pc_ff         <= nxt_pc;
      core_rst_n_ff <= ~in_reset;
      exec_en_ff    <= (nxt_state == `CRP_ST_RUN);
    end
  end

  // Vector read while held in reset, instruction fetch while running.
  assign mem_req  = (state_ff == `CRP_ST_VECTOR) ||
                    (state_ff == `CRP_ST_RUN && !in_reset);
  assign mem_addr = (state_ff == `CRP_ST_VECTOR) ? `CRP_RESET_VECTOR
                                                 : pc_ff;

  assign core_reset_n = core_rst_n_ff;
  assign exec_en      = exec_en_ff;
  assign pc           = pc_ff;

endmodule // crp_clock_reset_pins

// ==== crp_clock_reset_pins_sva.sv ====
`timescale 1ns/100ps
// Watches the pin drivers, reset sequencing and fetch order.
module crp_chk (
  input wire        clk,
  input wire        rst_n,
  input wire        clock_out_pin,
  input wire        clock_out_pin_oe_n,
  input wire        clock_out_disable,
  input wire        reset_pin_n_out,
  input wire        reset_pin_n_oe_n,
  input wire        wdog_reset_req,
  input wire        core_reset_n,
  input wire        exec_en,
  input wire        mem_req,
  input wire        mem_ack,
  input wire [21:0] mem_addr,
  input wire [21:0] mem_rdata,
  input wire [21:0] pc
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // The clock pin is checked through reset as well.
  AST_CK_OE: assert property (disable iff (1'h0) !clock_out_pin_oe_n)
    else $error("clock pin released");
  AST_OD: assert property (!reset_pin_n_out)
    else $error("reset pin driven high");
  AST_OFF: assert property (clock_out_disable [*3] |-> !clock_out_pin)
    else $error("stopped clock toggles");
  AST_WD: assert property (wdog_reset_req && reset_pin_n_oe_n |=>
    !reset_pin_n_oe_n) else $error("watchdog drive missing");
  AST_WD_RST: assert property (!reset_pin_n_oe_n |=> !core_reset_n)
    else $error("drive without internal reset");
  AST_HALT: assert property (!core_reset_n |-> !exec_en)
    else $error("running in reset");
  AST_VEC: assert property (mem_req && !exec_en |->
    mem_addr == 22'h3FFFC0) else $error("vector address wrong");
  AST_PC_LD: assert property (mem_req && mem_ack && !exec_en |=>
    pc == $past(mem_rdata)) else $error("vector not loaded");
  AST_STEP: assert property (mem_ack && exec_en && core_reset_n |=>
    pc == $past(pc) + 22'h000001) else $error("fetch step wrong");
endmodule // crp_chk

bind crp_clock_reset_pins crp_chk u_crp_chk (.*);

// ==== crp_board_model.sv ====
`timescale 1ns/100ps
// Board side: free oscillator, pulled-up reset wire and program memory.
module crp_board_model (
  input  wire        clk,
  input  wire        ext_low,
  input  wire        reset_pin_n_out,
  input  wire        reset_pin_n_oe_n,
  output wire        reset_pin_n_in,
  output reg         oscillator_clock,
  input  wire        mem_req,
  input  wire [21:0] mem_addr,
  output reg         mem_ack = 1'h0,
  output reg  [21:0] mem_rdata = 22'h000000
);
  reg [1:0] wait_ff = 2'h0;
  wire      take;
  // Oscillator is offset so its edges never meet a system clock edge.
  initial
  begin
    oscillator_clock = 1'h0;
    #3;
    forever #110 oscillator_clock = !oscillator_clock;
  end
  // Any low driver wins on the wire, else the pullup gives a high.
  assign reset_pin_n_in = !((!reset_pin_n_oe_n && !reset_pin_n_out) ||
                            ext_low);
  // Memory answers after a varying wait; unread data keeps changing.
  assign take = mem_req && !mem_ack && wait_ff != 2'h0;
  always @(posedge clk)
  begin
    wait_ff <= wait_ff + 2'h1;
    mem_ack <= take;
    mem_rdata <= !take ? ~mem_rdata :
                 (mem_addr == 22'h3FFFC0) ? 22'h001230 : ~mem_addr;
  end
endmodule // crp_board_model

// ==== crp_clock_reset_pins_bench.sv ====
`timescale 1ns/100ps
module crp_clock_reset_pins_bench;
  reg         clk = 1'h0, rst_n = 1'h0, cfg_wr = 1'h0, ext_low = 1'h0;
  reg         cfg_clock_out_half_select = 1'h0, wdog_reset_req = 1'h0;
  reg         cfg_clock_out_disable = 1'h0;
  reg  [2:0]  cfg_ext_timing_clock_ratio = 3'h0, sync_ff = 3'h0;
  reg  [31:0] rnd = 32'h00017674;
  wire [2:0]  ext_timing_clock_ratio;
  wire        clock_out_half_select, clock_out_disable, clock_out_pin;
  wire        clock_out_pin_oe_n, oscillator_clock, reset_pin_n_in;
  wire        reset_pin_n_out, reset_pin_n_oe_n, core_reset_n, exec_en;
  wire        mem_req, mem_ack;
  wire [21:0] mem_addr, mem_rdata, pc;
  integer     num_errors = 0, checked = 0, osc_cnt = 0, i, p;
  crp_clock_reset_pins u_crp_clock_reset_pins (.*);
  crp_board_model u_crp_board_model (.*);
  // System clock of 50 ns.
  always #25 clk = !clk;
  // Mirrors the pin synchroniser and counts oscillator rises under drive.
  always @(posedge clk)
  begin
    sync_ff <= {sync_ff[1:0], oscillator_clock};
    if (wdog_reset_req)
      osc_cnt <= 0;
    else if (!reset_pin_n_oe_n && sync_ff[1] && !sync_ff[2])
      osc_cnt <= osc_cnt + 1;
  end
  // Next xorshift value.
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // Output rises expected in 16 system clocks.
  function [31:0] per(input [2:0] r, input h, input d);
    per = d ? 0 : 16 / ((r != 3'h0 ? 2 : 1) * (h ? 2 : 1));
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        num_errors = num_errors + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // Loads the output configuration and lets it settle.
  task wr(input [2:0] r, input h, input d);
    begin
      @(posedge clk);
      cfg_wr <= 1'h1;
      cfg_ext_timing_clock_ratio <= r;
      cfg_clock_out_half_select <= h;
      cfg_clock_out_disable <= d;
      @(posedge clk);
      cfg_wr <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  // Counts output rises over 16 system clocks, sampling both edges.
  task meas;
    reg prv;
    begin
      p = 0;
      repeat (32)
      begin
        prv = clock_out_pin;
        @(clk);
        #1;
        p = p + (clock_out_pin === 1'h1 && prv === 1'h0);
      end
    end
  endtask
  // Bounded wait for run (0) or released drive (1).
  task await(input integer sel);
    integer n;
    begin
      n = 0;
      while ((sel ? reset_pin_n_oe_n : exec_en) !== 1'h1 && n < 3000)
      begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      if (n == 3000)
      begin
        num_errors = num_errors + 1;
        complete_run;
      end
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    check(clock_out_half_select, 1'h1);
    check(ext_timing_clock_ratio, 3'h1);
    meas;
    check(p, 4);
    for (i = 0; i < 12; i = i + 1)
    begin
      rnd = xs(rnd);
      // Corners: full rate, stopped quarter, half by select, stopped full.
      if (i < 4)
        rnd[5:0] = (i == 0) ? 6'h10 : (i == 1) ? 6'h0B :
                   (i == 2) ? 6'h18 : 6'h00;
      wr(rnd[2:0], rnd[3], rnd[5:4] == 2'h0);
      check(clock_out_disable, rnd[5:4] == 2'h0);
      check(ext_timing_clock_ratio, rnd[2:0]);
      meas;
      check(p, per(rnd[2:0], rnd[3], rnd[5:4] == 2'h0));
    end
    // Outside reset: write refused, /4 restored, clock still running.
    @(posedge clk);
    ext_low <= 1'h1;
    repeat (4) @(posedge clk);
    wr(3'h0, 1'h0, 1'h1);
    check(core_reset_n, 1'h0);
    check(exec_en, 1'h0);
    check(clock_out_disable, 1'h0);
    check(ext_timing_clock_ratio, 3'h1);
    check(clock_out_pin_oe_n, 1'h0);
    meas;
    check(p, 4);
    @(posedge clk);
    ext_low <= 1'h0;
    #1;
    await(0);
    check(pc, 22'h001230);
    // Watchdog drive and restart from the vector.
    @(posedge clk);
    wdog_reset_req <= 1'h1;
    @(posedge clk);
    wdog_reset_req <= 1'h0;
    #1;
    check(reset_pin_n_oe_n, 1'h0);
    check(reset_pin_n_out, 1'h0);
    await(1);
    check(osc_cnt, 512);
    await(0);
    check(pc, 22'h001230);
    complete_run;
  end
endmodule // crp_clock_reset_pins_bench
